/* hdl/ccr_pkg.sv */
package ccr_pkg;

  // Serial bus slave address, 7 bits
  localparam logic [6:0] DEVICE_ADDR = 7'h6b;

  // Register offsets
  localparam logic [7:0] POWER_ON_CONFIGURATION_OFFSET = 8'h01;
  localparam logic [7:0] FAST_CHARGE_CURRENT_CONTROL_OFFSET = 8'h02;
  localparam logic [7:0] PRECHARGE_TERMINATION_CURRENT_OFFSET = 8'h03;

  // Reset values
  localparam logic [7:0] POWER_ON_CONFIGURATION_RESET = 8'h1b;
  localparam logic [7:0] FAST_CHARGE_CURRENT_CONTROL_RESET = 8'h60;
  localparam logic [7:0] PRECHARGE_TERMINATION_CURRENT_RESET = 8'h11;

  // Power-on configuration fields
  localparam int REGISTER_RESET_BIT = 7;
  localparam int WATCHDOG_RESET_BIT = 6;
  localparam int MODE_MSB = 5;
  localparam int MODE_LSB = 4;
  localparam int MIN_SYS_MSB = 3;
  localparam int MIN_SYS_LSB = 1;
  localparam int BOOST_LIMIT_BIT = 0;

  // Fast charge current fields
  localparam int FAST_CHG_MSB = 7;
  localparam int FAST_CHG_LSB = 2;
  localparam int FAST_CHG_RESERVED_BIT = 1;
  localparam int FORCE_FIFTH_BIT = 0;

  // Precharge / termination fields
  localparam int PRECHG_MSB = 7;
  localparam int PRECHG_LSB = 4;
  localparam int TERM_MSB = 3;
  localparam int TERM_LSB = 0;

  // Charger mode encodings
  localparam logic [1:0] MODE_CHARGE_DISABLE = 2'h0;
  localparam logic [1:0] MODE_CHARGE_BATTERY = 2'h1;

  // Decoded setting scales
  localparam logic [11:0] MIN_SYS_OFFSET_MV = 12'hbb8;
  localparam logic [11:0] MIN_SYS_STEP_MV = 12'h064;
  localparam logic [12:0] FAST_CHG_OFFSET_MA = 13'h0200;
  localparam logic [12:0] FAST_CHG_STEP_MA = 13'h0040;
  localparam logic [12:0] FIFTH_DIVISOR = 13'h0005;
  localparam logic [11:0] NIBBLE_OFFSET_MA = 12'h080;
  localparam logic [11:0] NIBBLE_STEP_MA = 12'h080;
  localparam logic [10:0] BOOST_LOW_MA = 11'h1f4;
  localparam logic [10:0] BOOST_HIGH_MA = 11'h514;

  typedef struct packed {
    logic [1:0] charger_mode_select;
    logic [2:0] minimum_system_voltage;
    logic boost_current_limit;
    logic [5:0] fast_charge_current;
    logic force_fifth_current;
    logic [3:0] precharge_current;
    logic [3:0] termination_current;
  } ccr_cfg_t;

  typedef struct packed {
    logic [11:0] minimum_system_mv;
    logic [10:0] boost_limit_ma;
    logic [12:0] fast_charge_ma;
    logic [11:0] precharge_ma;
    logic [11:0] termination_ma;
  } ccr_levels_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_WRITE = 3'h2,
    ST_READ = 3'h6,
    ST_RACK = 3'h7
  } ccr_state_t;

endpackage

/* hdl/ccr_current_decode.sv */
`timescale 1ns/1ps
module ccr_current_decode (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input ccr_pkg::ccr_cfg_t cfg_i,
  output ccr_pkg::ccr_levels_t levels_o
);
  import ccr_pkg::*;

  logic [12:0] programmed_ma;

  assign programmed_ma = FAST_CHG_OFFSET_MA +
      13'(cfg_i.fast_charge_current) * FAST_CHG_STEP_MA; // see RQ6

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      levels_o <= '0;
    end else begin
      levels_o.minimum_system_mv <= MIN_SYS_OFFSET_MV +
          12'(cfg_i.minimum_system_voltage) * MIN_SYS_STEP_MV; // see RQ4
      levels_o.boost_limit_ma <= cfg_i.boost_current_limit ? BOOST_HIGH_MA
                                                            : BOOST_LOW_MA; // see RQ5
      levels_o.fast_charge_ma <= cfg_i.force_fifth_current ? programmed_ma / FIFTH_DIVISOR
                                                            : programmed_ma; // see RQ8
      levels_o.precharge_ma <= NIBBLE_OFFSET_MA +
          12'(cfg_i.precharge_current) * NIBBLE_STEP_MA; // see RQ9
      levels_o.termination_ma <= NIBBLE_OFFSET_MA +
          12'(cfg_i.termination_current) * NIBBLE_STEP_MA; // see RQ9
    end
  end

endmodule

/* hdl/ccr_config_registers.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Writing one to the register-reset bit restores every register to default and the bit reads zero.
// RQ2 - Writing one to the watchdog-reset bit restarts the watchdog and the bit reads zero; the code gives no restart if the register-reset bit is also one.
// RQ3 - The mode field gives charge disabled for 00, charging for 01 and boost for 10 or 11.
// RQ4 - The minimum system voltage code means 3.0 V plus 0.1 V per step, default 101.
// RQ5 - The boost limit bit chooses 500 mA at zero and 1.3 A at one, default one.
// RQ6 - The fast-charge code in bits 7:2 means 512 mA plus 64 mA per step, default 011000.
// RQ7 - The host writes zero to the reserved bit 1 of the charge current register.
// RQ8 - With the force bit set the applied fast-charge current is a fifth of the programmed one.
// RQ9 - Precharge and termination nibbles mean 128 mA plus 128 mA per step, default 0001.
// RQ10 - Reset values are 1b, 60 and 11 for the three registers.
// RQ11 - The host restarts the watchdog in time or disables it to stay in host mode.
// RQ12 - The three configuration registers are readable and writable over the serial bus.
// RQ13 - Every field other than the self-clearing bits reads back what was last written; the reserved bit 1 reads zero.
module ccr_config_registers (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output ccr_pkg::ccr_cfg_t cfg_o,
  output ccr_pkg::ccr_levels_t levels_o,
  output logic charge_enable_o,
  output logic boost_mode_o,
  output logic register_reset_o,
  output logic watchdog_restart_o
);
  import ccr_pkg::*;

  ccr_state_t state;
  logic scl_q;
  logic sda_q;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [2:0] bit_cnt;
  logic got_byte;
  logic read_dir;
  logic addr_phase;
  logic [7:0] ptr;
  ccr_cfg_t cfg;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic ptr_valid;
  logic byte_close;
  logic wr_fire;
  logic [7:0] rdata;

  assign scl_rise = scl_i && !scl_q;
  assign scl_fall = !scl_i && scl_q;
  assign start_seen = scl_i && scl_q && sda_q && !sda_i;
  assign stop_seen = scl_i && scl_q && !sda_q && sda_i;
  assign ptr_valid = (ptr >= POWER_ON_CONFIGURATION_OFFSET) &&
                     (ptr <= PRECHARGE_TERMINATION_CURRENT_OFFSET);
  assign byte_close = scl_fall && got_byte;
  assign wr_fire = byte_close && (state == ST_WRITE) && !addr_phase && ptr_valid; // see RQ12

  // Read view of the registers; self-clearing bits and the reserved bit read zero
  always_comb begin
    rdata = 8'h00;
    if (ptr == POWER_ON_CONFIGURATION_OFFSET) begin
      rdata[MODE_MSB:MODE_LSB] = cfg.charger_mode_select; // see RQ13
      rdata[MIN_SYS_MSB:MIN_SYS_LSB] = cfg.minimum_system_voltage;
      rdata[BOOST_LIMIT_BIT] = cfg.boost_current_limit;
    end else if (ptr == FAST_CHARGE_CURRENT_CONTROL_OFFSET) begin
      rdata[FAST_CHG_MSB:FAST_CHG_LSB] = cfg.fast_charge_current; // see RQ13
      rdata[FORCE_FIFTH_BIT] = cfg.force_fifth_current;
    end else if (ptr == PRECHARGE_TERMINATION_CURRENT_OFFSET) begin
      rdata[PRECHG_MSB:PRECHG_LSB] = cfg.precharge_current; // see RQ13
      rdata[TERM_MSB:TERM_LSB] = cfg.termination_current;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Serial bus slave: address, register pointer, write data, read data
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt <= 3'h0;
      got_byte <= 1'b0;
      read_dir <= 1'b0;
      addr_phase <= 1'b0;
      ptr <= 8'h00;
      sda_oe_o <= 1'b0;
    end else if (start_seen) begin
      state <= ST_ADDR;
      bit_cnt <= 3'h0;
      got_byte <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (stop_seen) begin
      state <= ST_IDLE;
      got_byte <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            shift_in <= {shift_in[6:0], sda_i};
            bit_cnt <= bit_cnt + 3'h1;
            got_byte <= (bit_cnt == 3'h7);
          end else if (byte_close) begin
            got_byte <= 1'b0;
            if (state == ST_ADDR) begin
              if (shift_in[7:1] == DEVICE_ADDR) begin
                read_dir <= shift_in[0];
                addr_phase <= !shift_in[0];
                sda_oe_o <= 1'b1;
                state <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end else if (addr_phase) begin
              ptr <= shift_in;
              addr_phase <= 1'b0;
              if ((shift_in >= POWER_ON_CONFIGURATION_OFFSET) &&
                  (shift_in <= PRECHARGE_TERMINATION_CURRENT_OFFSET)) begin
                sda_oe_o <= 1'b1;
                state <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end else if (ptr_valid) begin
              ptr <= ptr + 8'h01;
              sda_oe_o <= 1'b1;
              state <= ST_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (read_dir) begin
              shift_out <= rdata;
              sda_oe_o <= !rdata[7];
              state <= ST_READ;
            end else begin
              sda_oe_o <= 1'b0;
              state <= ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              sda_oe_o <= 1'b0;
              state <= ST_RACK;
            end else begin
              shift_out <= {shift_out[6:0], 1'b0};
              sda_oe_o <= !shift_out[6];
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_i) begin
              state <= ST_IDLE;
            end else begin
              ptr <= ptr + 8'h01;
              state <= ST_ACK;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Configuration storage
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg.charger_mode_select <= POWER_ON_CONFIGURATION_RESET[MODE_MSB:MODE_LSB]; // see RQ10
      cfg.minimum_system_voltage <= POWER_ON_CONFIGURATION_RESET[MIN_SYS_MSB:MIN_SYS_LSB];
      cfg.boost_current_limit <= POWER_ON_CONFIGURATION_RESET[BOOST_LIMIT_BIT];
      cfg.fast_charge_current <= FAST_CHARGE_CURRENT_CONTROL_RESET[FAST_CHG_MSB:FAST_CHG_LSB];
      cfg.force_fifth_current <= FAST_CHARGE_CURRENT_CONTROL_RESET[FORCE_FIFTH_BIT];
      cfg.precharge_current <= PRECHARGE_TERMINATION_CURRENT_RESET[PRECHG_MSB:PRECHG_LSB];
      cfg.termination_current <= PRECHARGE_TERMINATION_CURRENT_RESET[TERM_MSB:TERM_LSB];
    end else if (wr_fire && (ptr == POWER_ON_CONFIGURATION_OFFSET)) begin
      if (shift_in[REGISTER_RESET_BIT]) begin
        // Whole byte is discarded; all fields return to their defaults
        cfg.charger_mode_select <= POWER_ON_CONFIGURATION_RESET[MODE_MSB:MODE_LSB]; // see RQ1
        cfg.minimum_system_voltage <= POWER_ON_CONFIGURATION_RESET[MIN_SYS_MSB:MIN_SYS_LSB];
        cfg.boost_current_limit <= POWER_ON_CONFIGURATION_RESET[BOOST_LIMIT_BIT];
        cfg.fast_charge_current <= FAST_CHARGE_CURRENT_CONTROL_RESET[FAST_CHG_MSB:FAST_CHG_LSB];
        cfg.force_fifth_current <= FAST_CHARGE_CURRENT_CONTROL_RESET[FORCE_FIFTH_BIT];
        cfg.precharge_current <= PRECHARGE_TERMINATION_CURRENT_RESET[PRECHG_MSB:PRECHG_LSB];
        cfg.termination_current <= PRECHARGE_TERMINATION_CURRENT_RESET[TERM_MSB:TERM_LSB];
      end else begin
        cfg.charger_mode_select <= shift_in[MODE_MSB:MODE_LSB]; // see RQ3
        cfg.minimum_system_voltage <= shift_in[MIN_SYS_MSB:MIN_SYS_LSB]; // see RQ4
        cfg.boost_current_limit <= shift_in[BOOST_LIMIT_BIT]; // see RQ5
      end
    end else if (wr_fire && (ptr == FAST_CHARGE_CURRENT_CONTROL_OFFSET)) begin
      // Reserved bit is not stored and reads zero
      cfg.fast_charge_current <= shift_in[FAST_CHG_MSB:FAST_CHG_LSB]; // see RQ6, see RQ7
      cfg.force_fifth_current <= shift_in[FORCE_FIFTH_BIT]; // see RQ8
    end else if (wr_fire && (ptr == PRECHARGE_TERMINATION_CURRENT_OFFSET)) begin
      cfg.precharge_current <= shift_in[PRECHG_MSB:PRECHG_LSB]; // see RQ9
      cfg.termination_current <= shift_in[TERM_MSB:TERM_LSB]; // see RQ9
    end
  end

  // Outputs and one-cycle event pulses
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      register_reset_o <= 1'b0;
      watchdog_restart_o <= 1'b0;
      charge_enable_o <= 1'b0;
      boost_mode_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      register_reset_o <= wr_fire && (ptr == POWER_ON_CONFIGURATION_OFFSET) &&
                          shift_in[REGISTER_RESET_BIT]; // see RQ1
      watchdog_restart_o <= wr_fire && (ptr == POWER_ON_CONFIGURATION_OFFSET) &&
                            !shift_in[REGISTER_RESET_BIT] &&
                            shift_in[WATCHDOG_RESET_BIT]; // see RQ2
      charge_enable_o <= (cfg.charger_mode_select == MODE_CHARGE_BATTERY); // see RQ3
      boost_mode_o <= cfg.charger_mode_select[1]; // see RQ3
      sda_o <= 1'b0;
    end
  end

  assign cfg_o = cfg;

  ccr_current_decode u_decode (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .cfg_i(cfg),
    .levels_o(levels_o)
  );

endmodule

/* tb/ccr_config_registers_sva.sv */
`timescale 1ns/1ps
module ccr_config_registers_sva (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input ccr_pkg::ccr_cfg_t cfg_o,
  input ccr_pkg::ccr_levels_t levels_o,
  input wire logic charge_enable_o,
  input wire logic boost_mode_o,
  input wire logic register_reset_o,
  input wire logic watchdog_restart_o
);
  import ccr_pkg::*;
  localparam ccr_cfg_t DEF_CFG = {MODE_CHARGE_BATTERY, 3'h5, 1'h1, 6'h18, 1'h0, 4'h1, 4'h1};
  logic [12:0] fast_chg_ma;
  assign fast_chg_ma = FAST_CHG_OFFSET_MA + FAST_CHG_STEP_MA * 13'(cfg_o.fast_charge_current);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_OPEN_DRAIN: assert property (sda_o == 1'h0)
    else $error("data line driven high");
  AST_ACK_IN_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("data line pulled while clock high");
  AST_CHARGE_EN: assert property ($past(reset_n_i) |->
    charge_enable_o == ($past(cfg_o.charger_mode_select) == MODE_CHARGE_BATTERY))
    else $error("charge enable wrong");
  AST_BOOST_MODE: assert property ($past(reset_n_i) |->
    boost_mode_o == $past(cfg_o.charger_mode_select[1])) else $error("boost mode wrong");
  AST_MIN_SYSTEM: assert property ($past(reset_n_i) |-> levels_o.minimum_system_mv ==
    MIN_SYS_OFFSET_MV + MIN_SYS_STEP_MV * $past(cfg_o.minimum_system_voltage))
    else $error("system voltage level wrong");
  AST_BOOST_LIMIT: assert property ($past(reset_n_i) |-> levels_o.boost_limit_ma ==
    ($past(cfg_o.boost_current_limit) ? BOOST_HIGH_MA : BOOST_LOW_MA))
    else $error("boost limit wrong");
  AST_FAST_CHARGE: assert property ($past(reset_n_i) |-> levels_o.fast_charge_ma ==
    ($past(cfg_o.force_fifth_current) ? $past(fast_chg_ma) / FIFTH_DIVISOR : $past(fast_chg_ma)))
    else $error("fast charge level wrong");
  AST_NIBBLES: assert property ($past(reset_n_i) |->
    levels_o.precharge_ma == NIBBLE_OFFSET_MA + NIBBLE_STEP_MA * $past(cfg_o.precharge_current)
    && levels_o.termination_ma == NIBBLE_OFFSET_MA
    + NIBBLE_STEP_MA * $past(cfg_o.termination_current)) else $error("nibble level wrong");
  AST_RESET_DEFAULTS: assert property (register_reset_o |->
    cfg_o == DEF_CFG && !watchdog_restart_o ##1 !register_reset_o)
    else $error("register reset did not restore defaults");
  AST_WD_PULSE: assert property (watchdog_restart_o |-> !scl_i ##1 !watchdog_restart_o)
    else $error("watchdog restart pulse wrong");
endmodule
bind ccr_config_registers ccr_config_registers_sva u_sva (.sys_clk_i, .reset_n_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_o, .cfg_o, .levels_o, .charge_enable_o, .boost_mode_o,
  .register_reset_o, .watchdog_restart_o);

/* tb/ccr_host_model.sv */
`timescale 1ns/1ps
module ccr_host_model (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Half period of the serial clock in system cycles; raise it for a slow host
  int hp = 4;
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #10;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    tick(hp);
    scl_o = 1'h1;
    tick(hp);
    r = sda_i;
    scl_o = 1'h0;
    tick(1);
  endtask
  task automatic start();
    sda_o = 1'h1;
    tick(hp);
    scl_o = 1'h1;
    tick(hp);
    sda_o = 1'h0;
    tick(hp);
    scl_o = 1'h0;
    tick(1);
  endtask
  task automatic stop();
    sda_o = 1'h0;
    tick(hp);
    scl_o = 1'h1;
    tick(hp);
    sda_o = 1'h1;
    tick(hp);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q,
                         output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, a);
    ack = ~a;
  endtask
endmodule

/* tb/ccr_config_registers_bench.sv */
`timescale 1ns/1ps
module ccr_config_registers_bench;
  import ccr_pkg::*;
  logic sys_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic scl, hsda, sda_o, sda_oe_o, chg_en, boost, rr_o, wd_o, a;
  logic [7:0] x;
  ccr_cfg_t cfg_o;
  ccr_levels_t lv;
  wire logic sda_line = hsda & (sda_oe_o ? sda_o : 1'h1);
  int err_count = 0;
  int total_checks = 0;
  int rr_n = 0;
  int wd_n = 0;
  logic aq [$];
  ccr_config_registers u_dut (.sys_clk_i, .reset_n_i, .scl_i(scl), .sda_i(sda_line), .sda_o,
    .sda_oe_o, .cfg_o, .levels_o(lv), .charge_enable_o(chg_en), .boost_mode_o(boost),
    .register_reset_o(rr_o), .watchdog_restart_o(wd_o));
  ccr_host_model u_host (.sys_clk_i, .sda_i(sda_line), .scl_o(scl), .sda_o(hsda));
  initial forever #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (rr_o === 1'h1) rr_n++;
    if (wd_o === 1'h1) wd_n++;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_ack(input logic [23:0] e);
    logic [23:0] v;
    v = '0;
    foreach (aq[i]) v = {v[22:0], aq[i]};
    chk("ack", e, v);
  endtask
  task automatic hdr(input logic [7:0] r);
    aq = {};
    u_host.start();
    u_host.byte_io({DEVICE_ADDR, 1'h0}, 1'h1, x, a);
    aq.push_back(a);
    u_host.byte_io(r, 1'h1, x, a);
    aq.push_back(a);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d [$]);
    hdr(r);
    foreach (d[i]) begin
      u_host.byte_io(d[i], 1'h1, x, a);
      aq.push_back(a);
    end
    u_host.stop();
  endtask
  task automatic rdchk(input logic [7:0] r, input logic [7:0] e [$]);
    hdr(r);
    u_host.start();
    u_host.byte_io({DEVICE_ADDR, 1'h1}, 1'h1, x, a);
    aq.push_back(a);
    foreach (e[i]) begin
      u_host.byte_io(8'hff, i == e.size() - 1, x, a);
      chk("read", e[i], x);
    end
    u_host.stop();
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    err_count++;
    end_sim();
  end
  initial begin
    logic [7:0] b;
    repeat (10) @(posedge sys_clk_i);
    #10 reset_n_i = 1'h1;
    u_host.tick(4);
    chk("cfg", {3'h0, MODE_CHARGE_BATTERY, 19'h5b011}, cfg_o);
    rdchk(8'h01, {8'h1b, 8'h60, 8'h11});
    chk_ack(24'h7);
    wr(8'h01, {8'h25, 8'hfd, 8'hf0});
    chk_ack(24'h1f);
    chk("fifth", 24'h38c, lv.fast_charge_ma);
    chk("prechg", 24'h800, lv.precharge_ma);
    chk("term", 24'h080, lv.termination_ma);
    u_host.hp = 8;
    rdchk(8'h01, {8'h25, 8'hfd, 8'hf0});
    u_host.hp = 4;
    for (int m = 0; m < 4; m++) begin
      b = {2'(m), 3'h7, 1'h0};
      wr(8'h01, {b});
      chk("chg_en", m == 1, chg_en);
      chk("boost", m / 2, boost);
    end
    chk("sysmin", 24'he74, lv.minimum_system_mv);
    chk("blim", 24'h1f4, lv.boost_limit_ma);
    wr(8'h02, {8'h00});
    chk("fast_chg", 24'h200, lv.fast_charge_ma);
    wr(8'h01, {8'h4a});
    chk("wd", 24'h1, wd_n);
    rdchk(8'h01, {8'h0a});
    wr(8'h01, {8'hc0});
    chk("rr", 24'h1, rr_n);
    chk("wd", 24'h1, wd_n);
    rdchk(8'h01, {8'h1b, 8'h60, 8'h11});
    wr(8'h04, {8'h55});
    chk_ack(24'h4);
    wr(8'h03, {8'h22, 8'h33});
    chk_ack(24'he);
    rdchk(8'h03, {8'h22});
    u_host.start();
    u_host.byte_io({DEVICE_ADDR ^ 7'h01, 1'h0}, 1'h1, x, a);
    u_host.stop();
    chk("addr_ack", 24'h0, a);
    end_sim();
  end
endmodule
